// file: design/dbwb_bridge.sv
// disk buffer width bridge top: 24-bit exchange to 16-bit controller
// How it works
// - exchange side moves 24-bit words, controller side 16-bit words.
// - the buffer is touched one byte per access: three or two.
// - five sectors, 900 bytes, are buffered between the two sides.
// - free space is tracked; short space commands the controller to slip.
// - while idle the bridge polls drives for seek-complete.
// - a seek-complete drive found by polling raises the interrupt.
// - lost controller link for over one second is reported.
// - five input bytes share the ram data input, selected one at a time.
// - exchange input takes the address on accept plus first out in 7-9.
// - exchange input takes write data on read condition plus second out.
// - controller input bytes load on controller write request.
// - exchange output register and two cascaded 16-bit controller stages.
// - memory control loads exchange out and stage one; request loads two.
// - exchange output drives only on transfer-in in counts 7,8,9,15.
// - stage two drives the info bus in the read data phase.
// - the buffer is 1024 bytes, written from inputs, read to outputs.
// - address bytes sit in words one to three, counter wraps 3 to 1.
// - data counters run from 0x05E to the top, then wrap to start.
`timescale 1ns/1ps
`include "dbwb_regs.svh"
module dbwb_bridge
  import dbwb_pkg::*;
#(
  parameter int TIMEOUT_CYCLES =
    int'(`DBWB_TIMEOUT_NS / `DBWB_CLOCK_NS)
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_srst,
  input  wire dbwb_pkg::dbwb_xchg_in_t i_xchg,
  input  wire dbwb_pkg::dbwb_ctrl_in_t i_ctrl,
  input  wire logic                    i_seek_done,
  output logic                  [23:0] o_xchg_data,
  output logic                         o_xchg_data_oe,
  output logic                  [15:0] o_info_data,
  output logic                         o_info_data_oe,
  output logic                         o_slip,
  output logic                         o_interrupt,
  output logic                   [2:0] o_poll_unit,
  output logic                         o_timeout
);
  import dbwb_pkg::*;

  // the exchange, controller and seek-done inputs pass a two-flop synchroniser first; reset does not
  typedef struct packed {
    dbwb_xchg_in_t x1, x2;
    dbwb_ctrl_in_t c1, c2;
    logic          k1, k2;
  } dbwb_sync_t;

  typedef struct packed {
    logic [7:0]   x_in0, x_in1, x_in2;
    logic [7:0]   c_in0, c_in1;
    logic [23:0]  x_out;
    logic [15:0]  c_stage1, c_stage2;
    logic         x_oe, c_oe;
    logic [9:0]   ref_addr, sys_addr, ctl_addr;
    logic [10:0]  used;
    logic         slip, irq;
    logic         ref_wr_req, sys_wr_req, ctl_wr_req;
    logic         sys_rd_req, ctl_rd_req;
    logic [1:0]   step;
    dbwb_mstate_t mstate;
    logic         rd_pend;
    dbwb_mstate_t rd_kind;
    logic [1:0]   rd_step;
    logic         prev_first, prev_second, prev_cwr, prev_crd, prev_xin;
  } dbwb_state_t;

  dbwb_sync_t  y_reg;
  dbwb_state_t s_reg, s_next;
  logic        ram_we;
  logic [9:0]  ram_addr;
  logic [7:0]  ram_wdata, ram_rdata;
  dbwb_src_t   src;
  logic [2:0]  unit;
  logic        found, tmo;

  function automatic logic [9:0] buf_step(input logic [9:0] a);
    return (a == `DBWB_BUF_TOP) ? `DBWB_BUF_START : a + 10'h001;
  endfunction

  function automatic logic in_count(input logic [4:0] c,
                                    input logic       with15);
    return c == `DBWB_STC_SEVEN || c == `DBWB_STC_EIGHT ||
           c == `DBWB_STC_NINE || (with15 && c == `DBWB_STC_FIFTEEN);
  endfunction

  always_ff @(posedge i_clock) begin
    y_reg.x1 <= i_xchg;
    y_reg.x2 <= y_reg.x1;
    y_reg.c1 <= i_ctrl;
    y_reg.c2 <= y_reg.c1;
    y_reg.k1 <= i_seek_done;
    y_reg.k2 <= y_reg.k1;
  end

  // one source byte onto the shared ram input at a time
  always_comb begin
    unique case (src)
      DBWB_SRC_X0: ram_wdata = s_reg.x_in0;
      DBWB_SRC_X1: ram_wdata = s_reg.x_in1;
      DBWB_SRC_X2: ram_wdata = s_reg.x_in2;
      DBWB_SRC_C0: ram_wdata = s_reg.c_in0;
      DBWB_SRC_C1: ram_wdata = s_reg.c_in1;
      default:     ram_wdata = 8'h00;
    endcase
  end

  always_comb begin
    logic first_rise, second_rise, cwr_rise, crd_rise, xin_rise;
    logic sys_wr_done, ctl_rd_done, ctl_wr_done, sys_rd_done;
    logic ref_hit, sw_hit, sr_hit;
    first_rise  = y_reg.x2.exchange_transfer_out_first &&
                  !s_reg.prev_first;
    second_rise = y_reg.x2.exchange_transfer_out_second &&
                  !s_reg.prev_second;
    cwr_rise    = y_reg.c2.ctrl_side_ram_write_request && !s_reg.prev_cwr;
    crd_rise    = y_reg.c2.ctrl_side_ram_read_request && !s_reg.prev_crd;
    xin_rise    = y_reg.x2.exchange_transfer_in_command && !s_reg.prev_xin;
    sys_wr_done = 1'b0;
    ctl_rd_done = 1'b0;
    ctl_wr_done = 1'b0;
    sys_rd_done = 1'b0;
    ref_hit     = y_reg.x2.command_accept_strobe && first_rise &&
                  in_count(y_reg.x2.status_count, 1'b0);
    sw_hit      = y_reg.x2.read_command_condition && second_rise;
    sr_hit      = xin_rise && !in_count(y_reg.x2.status_count, 1'b1);
    s_next = s_reg;
    src = DBWB_SRC_NONE;
    ram_we = 1'b0;
    ram_addr = 10'h000;
    s_next.prev_first  = y_reg.x2.exchange_transfer_out_first;
    s_next.prev_second = y_reg.x2.exchange_transfer_out_second;
    s_next.prev_cwr    = y_reg.c2.ctrl_side_ram_write_request;
    s_next.prev_crd    = y_reg.c2.ctrl_side_ram_read_request;
    s_next.prev_xin    = y_reg.x2.exchange_transfer_in_command;

    if (ref_hit) begin
      {s_next.x_in2, s_next.x_in1, s_next.x_in0} = y_reg.x2.data;
      s_next.ref_wr_req = 1'b1;
    end
    if (sw_hit) begin
      {s_next.x_in2, s_next.x_in1, s_next.x_in0} = y_reg.x2.data;
      s_next.sys_wr_req = 1'b1;
    end
    if (cwr_rise) begin
      {s_next.c_in1, s_next.c_in0} = y_reg.c2.data;
      s_next.ctl_wr_req = 1'b1;
    end
    if (crd_rise) begin
      s_next.c_stage2 = s_reg.c_stage1;
      s_next.ctl_rd_req = 1'b1;
    end
    if (sr_hit) begin
      s_next.sys_rd_req = 1'b1;
    end

    // registered ram data lands one cycle after the read address
    if (s_reg.rd_pend) begin
      s_next.rd_pend = 1'b0;
      case (s_reg.rd_kind)
        DBWB_MS_REFR: s_next.x_out[7:0] = ram_rdata;
        DBWB_MS_SR: begin
          case (s_reg.rd_step)
            2'h0:    s_next.x_out[23:16] = ram_rdata;
            2'h1:    s_next.x_out[15:8] = ram_rdata;
            default: s_next.x_out[7:0] = ram_rdata;
          endcase
        end
        DBWB_MS_CR: begin
          if (s_reg.rd_step == 2'h0) begin
            s_next.c_stage1[15:8] = ram_rdata;
          end else begin
            s_next.c_stage1[7:0] = ram_rdata;
          end
        end
        default: ;
      endcase
    end

    // memory control: one byte access per cycle, fixed priority
    case (s_reg.mstate)
      DBWB_MS_IDLE: begin
        s_next.step = 2'h0;
        if (s_reg.ref_wr_req) begin
          s_next.mstate = DBWB_MS_REFW;
        end else if (s_reg.ctl_rd_req) begin
          s_next.mstate = DBWB_MS_CR;
        end else if (s_reg.ctl_wr_req) begin
          s_next.mstate = DBWB_MS_CW;
        end else if (s_reg.sys_rd_req) begin
          s_next.mstate = DBWB_MS_SR;
        end else if (s_reg.sys_wr_req) begin
          s_next.mstate = DBWB_MS_SW;
        end
      end
      DBWB_MS_REFW: begin
        src = DBWB_SRC_X0;
        ram_we = 1'b1;
        ram_addr = s_reg.ref_addr;
        s_next.ref_addr = (s_reg.ref_addr == `DBWB_REF_LAST) ?
                          `DBWB_REF_FIRST : s_reg.ref_addr + 10'h001;
        s_next.ref_wr_req = ref_hit; // a new capture wins over the clear
        s_next.mstate = DBWB_MS_IDLE;
      end
      DBWB_MS_SW: begin
        src = (s_reg.step == 2'h0) ? DBWB_SRC_X2 :
              (s_reg.step == 2'h1) ? DBWB_SRC_X1 : DBWB_SRC_X0;
        ram_we = 1'b1;
        ram_addr = s_reg.sys_addr;
        s_next.sys_addr = buf_step(s_reg.sys_addr);
        s_next.step = s_reg.step + 2'h1;
        if (s_reg.step == 2'h2) begin
          s_next.sys_wr_req = sw_hit;
          sys_wr_done = 1'b1;
          s_next.mstate = DBWB_MS_IDLE;
        end
      end
      DBWB_MS_CW: begin
        src = (s_reg.step == 2'h0) ? DBWB_SRC_C1 : DBWB_SRC_C0;
        ram_we = 1'b1;
        ram_addr = s_reg.ctl_addr;
        s_next.ctl_addr = buf_step(s_reg.ctl_addr);
        s_next.step = s_reg.step + 2'h1;
        if (s_reg.step == 2'h1) begin
          s_next.ctl_wr_req = cwr_rise;
          ctl_wr_done = 1'b1;
          s_next.mstate = DBWB_MS_IDLE;
        end
      end
      DBWB_MS_CR, DBWB_MS_SR: begin
        ram_addr = (s_reg.mstate == DBWB_MS_CR) ? s_reg.ctl_addr
                                                : s_reg.sys_addr;
        s_next.rd_pend = 1'b1;
        s_next.rd_kind = s_reg.mstate;
        s_next.rd_step = s_reg.step;
        s_next.step = s_reg.step + 2'h1;
        if (s_reg.mstate == DBWB_MS_CR) begin
          s_next.ctl_addr = buf_step(s_reg.ctl_addr);
          if (s_reg.step == 2'h1) begin
            s_next.ctl_rd_req = crd_rise;
            ctl_rd_done = 1'b1;
            s_next.mstate = DBWB_MS_IDLE;
          end
        end else begin
          s_next.sys_addr = buf_step(s_reg.sys_addr);
          if (s_reg.step == 2'h2) begin
            s_next.sys_rd_req = sr_hit;
            sys_rd_done = 1'b1;
            s_next.mstate = DBWB_MS_IDLE;
          end
        end
      end
      DBWB_MS_REFR: begin
        s_next.mstate = DBWB_MS_IDLE;
      end
      default: begin
        s_next.mstate = DBWB_MS_IDLE;
      end
    endcase

    // occupancy: writes into the ring fill it, reads out drain it; only
    // one access runs per cycle, so at most one of the four is set
    if (sys_wr_done || ctl_wr_done) begin
      s_next.used = s_reg.used + (sys_wr_done ? 11'h003 : 11'h002);
    end else if (sys_rd_done || ctl_rd_done) begin
      s_next.used = s_reg.used - (sys_rd_done ? 11'h003 : 11'h002);
    end
    // compare against the fill level so an overfull ring still slips
    s_next.slip = s_next.used > (`DBWB_BUF_BYTES - `DBWB_SLIP_BYTES);

    s_next.x_oe = y_reg.x2.exchange_transfer_in_command &&
                  in_count(y_reg.x2.status_count, 1'b1);
    s_next.c_oe = y_reg.c2.read_data_phase;
    s_next.irq = found;

    if (i_srst) begin
      s_next = '0;
      s_next.mstate = DBWB_MS_IDLE;
      s_next.ref_addr = `DBWB_REF_FIRST;
      s_next.sys_addr = `DBWB_BUF_START;
      s_next.ctl_addr = `DBWB_BUF_START;
    end
  end

  always_ff @(posedge i_clock) begin
    s_reg <= s_next;
  end

  dbwb_ram u_ram (
    .i_clock (i_clock),
    .i_we    (ram_we),
    .i_addr  (ram_addr),
    .i_wdata (ram_wdata),
    .o_rdata (ram_rdata)
  );

  logic cwr_seen_w;
  assign cwr_seen_w = y_reg.c2.ctrl_side_ram_write_request ||
                      y_reg.c2.ctrl_side_ram_read_request;

  // polling runs only while the exchange side shows no accept strobe and no transfer-in; write data does not stop it
  dbwb_poll #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_poll (
    .i_clock       (i_clock),
    .i_srst        (i_srst),
    .i_idle        (!y_reg.x2.command_accept_strobe &&
                    !y_reg.x2.exchange_transfer_in_command),
    .i_seek_done   (y_reg.k2),
    .i_link_active (y_reg.c2.link_active),
    .i_link_seen   (cwr_seen_w),
    .o_unit        (unit),
    .o_found       (found),
    .o_timeout     (tmo)
  );

  assign o_xchg_data    = s_reg.x_out;
  assign o_xchg_data_oe = s_reg.x_oe;
  assign o_info_data    = s_reg.c_stage2;
  assign o_info_data_oe = s_reg.c_oe;
  assign o_slip         = s_reg.slip;
  assign o_interrupt    = s_reg.irq;
  assign o_poll_unit    = unit;
  assign o_timeout      = tmo;

  logic crd_chk;
  assign crd_chk = y_reg.c2.ctrl_side_ram_read_request && !s_reg.prev_crd;

  a_oe_window: assert property (@(posedge i_clock) disable iff (i_srst)
    s_reg.x_oe |-> $past(y_reg.x2.exchange_transfer_in_command) &&
                   in_count($past(y_reg.x2.status_count), 1'b1))
    else $error("exchange drive outside its counts");
  a_one_source: assert property (@(posedge i_clock) disable iff (i_srst)
    ram_we |-> src != DBWB_SRC_NONE)
    else $error("write with no input byte selected");
  a_ref_wrap: assert property (@(posedge i_clock) disable iff (i_srst)
    s_reg.ref_addr >= `DBWB_REF_FIRST && s_reg.ref_addr <= `DBWB_REF_LAST)
    else $error("address byte counter out of range");
  a_buf_range: assert property (@(posedge i_clock) disable iff (i_srst)
    s_reg.sys_addr >= `DBWB_BUF_START && s_reg.ctl_addr >= `DBWB_BUF_START)
    else $error("data counter below start");
  a_sw_three: assert property (@(posedge i_clock) disable iff (i_srst)
    $rose(s_reg.mstate == DBWB_MS_SW) |-> ram_we [*3])
    else $error("exchange write not three bytes");
  a_cw_two: assert property (@(posedge i_clock) disable iff (i_srst)
    $rose(s_reg.mstate == DBWB_MS_CW) |-> ram_we [*2] ##1 !ram_we)
    else $error("controller write not two bytes");
  a_slip_level: assert property (@(posedge i_clock) disable iff (i_srst)
    ##1 (s_reg.slip == (s_reg.used > (`DBWB_BUF_BYTES - `DBWB_SLIP_BYTES))))
    else $error("slip does not follow free space");
  a_stage_two: assert property (@(posedge i_clock) disable iff (i_srst)
    crd_chk |=> s_reg.c_stage2 == $past(s_reg.c_stage1))
    else $error("stage two not loaded from stage one");
endmodule

// file: design/dbwb_regs.svh
// constants for the disk buffer width bridge
`ifndef DBWB_REGS_SVH
`define DBWB_REGS_SVH
`define DBWB_REF_FIRST   10'h001
`define DBWB_REF_LAST    10'h003
`define DBWB_BUF_START   10'h05E
`define DBWB_BUF_TOP     10'h3FF
`define DBWB_BUF_BYTES   11'h384
`define DBWB_SLIP_BYTES  11'h006
`define DBWB_STC_SEVEN   5'h07
`define DBWB_STC_EIGHT   5'h08
`define DBWB_STC_NINE    5'h09
`define DBWB_STC_FIFTEEN 5'h0F
`define DBWB_DRIVES      3'h7
`define DBWB_TIMEOUT_NS  64'd1000000000
`define DBWB_CLOCK_NS    64'd10
`endif

// file: design/dbwb_pkg.sv
// types shared by the disk buffer width bridge
package dbwb_pkg;
  typedef struct packed {
    logic        command_accept_strobe;
    logic        exchange_transfer_out_first;
    logic        exchange_transfer_out_second;
    logic        read_command_condition;
    logic        exchange_transfer_in_command;
    logic [4:0]  status_count;
    logic [23:0] data;
  } dbwb_xchg_in_t;
  typedef struct packed {
    logic        ctrl_side_ram_write_request;
    logic        ctrl_side_ram_read_request;
    logic        read_data_phase;
    logic        link_active;
    logic [15:0] data;
  } dbwb_ctrl_in_t;
  typedef enum logic [2:0] {
    DBWB_SRC_NONE, DBWB_SRC_X0, DBWB_SRC_X1, DBWB_SRC_X2,
    DBWB_SRC_C0, DBWB_SRC_C1
  } dbwb_src_t;
  typedef enum logic [2:0] {
    DBWB_MS_IDLE, DBWB_MS_REFW, DBWB_MS_REFR, DBWB_MS_CW,
    DBWB_MS_CR, DBWB_MS_SW, DBWB_MS_SR
  } dbwb_mstate_t;
endpackage

// file: design/dbwb_ram.sv
// 1024 x 8 buffer memory with registered read data
`timescale 1ns/1ps
module dbwb_ram (
  input  wire logic       i_clock,
  input  wire logic       i_we,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem_reg [0:1023];
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem_reg[i_addr] <= i_wdata;
    end
    o_rdata <= mem_reg[i_addr];
  end
endmodule

// file: design/dbwb_poll.sv
// drive poller and lost-link timer
`timescale 1ns/1ps
`include "dbwb_regs.svh"
module dbwb_poll #(
  parameter int TIMEOUT_CYCLES = 100000000
) (
  input  wire logic       i_clock,
  input  wire logic       i_srst,
  input  wire logic       i_idle,
  input  wire logic       i_seek_done,
  input  wire logic       i_link_active,
  input  wire logic       i_link_seen,
  output logic      [2:0] o_unit,
  output logic            o_found,
  output logic            o_timeout
);
  typedef struct packed {
    logic [2:0]  unit;
    logic        found;
    logic        timeout;
    logic [31:0] count;
  } dbwb_poll_state_t;
  dbwb_poll_state_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.found = 1'b0;
    if (i_idle) begin
      if (i_seek_done) begin
        s_next.found = 1'b1;
      end
      s_next.unit = (s_reg.unit == `DBWB_DRIVES) ? 3'h0
                                                 : s_reg.unit + 3'h1;
    end
    if (!i_link_active || i_link_seen) begin
      s_next.count = 32'h0;
      s_next.timeout = 1'b0;
    end else if (s_reg.count >= 32'(TIMEOUT_CYCLES)) begin
      s_next.timeout = 1'b1;
    end else begin
      s_next.count = s_reg.count + 32'h1;
    end
    if (i_srst) begin
      s_next = '0;
    end
  end
  always_ff @(posedge i_clock) begin
    s_reg <= s_next;
  end
  assign o_unit = s_reg.unit;
  assign o_found = s_reg.found;
  assign o_timeout = s_reg.timeout;
endmodule

// file: test/dbwb_ctrl_model.sv
// controller-side partner: issues write and read requests to the bridge
`timescale 1ns/1ps
module dbwb_ctrl_model
  import dbwb_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_link,
  input  wire logic               i_phase,
  output dbwb_pkg::dbwb_ctrl_in_t o_ctrl
);
  logic        wr;
  logic        rd;
  logic [15:0] data;
  logic [15:0] last;
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    data = 16'h0000;
    last = 16'h0000;
  end
  assign o_ctrl = '{wr, rd, i_phase, i_link, data};
  // released data lines show the inverse so a stale word never matches
  task automatic hold_req(input logic is_wr, input logic [15:0] d,
                          input int gap);
    @(posedge i_clock);
    wr <= is_wr;
    rd <= !is_wr;
    data <= d;
    last = d;
    repeat (4) @(posedge i_clock);
    wr <= 1'b0;
    rd <= 1'b0;
    data <= ~last;
    repeat (gap) @(posedge i_clock);
  endtask
endmodule

// file: test/tb_top.sv
// self-checking bench for the disk buffer width bridge
`timescale 1ns/1ps
module tb_top;
  import dbwb_pkg::*;
  localparam int TO = 50;
  logic          i_clock;
  logic          i_srst;
  logic          i_seek_done;
  logic          link;
  logic          phase;
  dbwb_xchg_in_t xin;
  dbwb_ctrl_in_t cin;
  logic [23:0]   o_xchg_data;
  logic          o_xchg_data_oe;
  logic [15:0]   o_info_data;
  logic          o_info_data_oe;
  logic          o_slip;
  logic          o_interrupt;
  logic [2:0]    o_poll_unit;
  logic          o_timeout;
  int            bad_count;
  int            num_checks;
  logic [31:0]   seed;
  logic          oe_seen;
  logic          held;
  logic [23:0]   xw [2];
  logic [15:0]   cw [3];
  logic [15:0]   got [3];
  logic [2:0]    u;
  int            k;
  int            i;
  logic [4:0]    cnts [4] = '{5'h07, 5'h08, 5'h09, 5'h0F};

  dbwb_bridge #(.TIMEOUT_CYCLES(TO)) dut (
    .i_clock        (i_clock),
    .i_srst         (i_srst),
    .i_xchg         (xin),
    .i_ctrl         (cin),
    .i_seek_done    (i_seek_done),
    .o_xchg_data    (o_xchg_data),
    .o_xchg_data_oe (o_xchg_data_oe),
    .o_info_data    (o_info_data),
    .o_info_data_oe (o_info_data_oe),
    .o_slip         (o_slip),
    .o_interrupt    (o_interrupt),
    .o_poll_unit    (o_poll_unit),
    .o_timeout      (o_timeout)
  );
  dbwb_ctrl_model pm (
    .i_clock (i_clock),
    .i_link  (link),
    .i_phase (phase),
    .o_ctrl  (cin)
  );

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // exchange words carry the high byte first, controller words too
  function automatic logic [23:0] xword(input logic [47:0] s, input int n);
    return s[47 - 24 * n -: 24];
  endfunction
  function automatic logic [15:0] cword(input logic [47:0] s, input int n);
    return s[47 - 16 * n -: 16];
  endfunction

  task automatic results();
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, lim);
      results();
    end
  endtask
  task automatic nxt();
    seed = lfsr(seed);
  endtask
  task automatic do_reset();
    @(posedge i_clock);
    i_srst <= 1'b1;
    repeat (16) @(posedge i_clock);
    i_srst <= 1'b0;
    @(negedge i_clock);
    chk({o_xchg_data, o_xchg_data_oe, o_info_data, o_info_data_oe, o_slip,
         o_interrupt, o_poll_unit, o_timeout}, 48'h0);
  endtask
  // kind 0: transfer-in, 1: processor write data, 2: address accept
  task automatic xpulse(input logic [4:0] cnt, input logic [23:0] d,
                        input int kind);
    @(posedge i_clock);
    xin.status_count <= cnt;
    xin.data <= d;
    xin.read_command_condition <= (kind == 1);
    xin.exchange_transfer_out_second <= (kind == 1);
    xin.exchange_transfer_in_command <= (kind == 0);
    xin.command_accept_strobe <= (kind == 2);
    xin.exchange_transfer_out_first <= (kind == 2);
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    u = o_poll_unit;
    @(negedge i_clock);
    oe_seen = o_xchg_data_oe;
    held = (o_poll_unit === u);
    @(posedge i_clock);
    xin.exchange_transfer_out_second <= 1'b0;
    xin.exchange_transfer_in_command <= 1'b0;
    xin.read_command_condition <= 1'b0;
    xin.command_accept_strobe <= 1'b0;
    xin.exchange_transfer_out_first <= 1'b0;
    xin.data <= ~d;
    repeat (12) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  initial begin
    repeat (100000) @(posedge i_clock);
    bad_count++;
    results();
  end

  initial begin
    i_srst = 1'b1;
    i_seek_done = 1'b0;
    link = 1'b0;
    phase = 1'b0;
    xin = '0;
    bad_count = 0;
    num_checks = 0;
    seed = 32'h000077AD;
    do_reset();
    for (i = 0; i < 3; i++) begin
      u = o_poll_unit;
      @(negedge i_clock);
      chk(o_poll_unit != u, 48'h1);
    end
    @(posedge i_clock);
    i_seek_done <= 1'b1;
    for (k = 0; k < 40 && o_interrupt !== 1'b1; k++) @(negedge i_clock);
    bound(k, 40);
    chk(o_interrupt, 48'h1);
    @(posedge i_clock);
    i_seek_done <= 1'b0;
    // fill to six free bytes, then one word more must command slip
    for (i = 0; i < 447; i++) begin
      nxt();
      pm.hold_req(1'b1, seed[15:0], 8 + int'(seed[19:16]));
    end
    repeat (10) @(negedge i_clock);
    chk(o_slip, 48'h0);
    pm.hold_req(1'b1, 16'hA55A, 10);
    @(negedge i_clock);
    chk(o_slip, 48'h1);
    do_reset();
    chk(o_slip, 48'h0);
    // three controller words become two exchange words
    for (i = 0; i < 3; i++) begin
      nxt();
      cw[i] = seed[15:0];
      pm.hold_req(1'b1, cw[i], 8 + int'(seed[18:16]));
    end
    for (i = 0; i < 2; i++) begin
      xpulse(5'h00, 24'h000000, 0);
      chk(oe_seen, 48'h0);
      chk(held, 48'h1);
      chk(o_xchg_data, xword({cw[0], cw[1], cw[2]}, i));
    end
    for (i = 0; i < 4; i++) begin
      xpulse(cnts[i], 24'h000000, 0);
      chk(oe_seen, 48'h1);
      chk(o_xchg_data_oe, 48'h0);
      chk(held, 48'h1);
      xpulse(cnts[i], seed[23:0], 2);
      chk(oe_seen, 48'h0);
      chk(held, 48'h1);
    end
    // two exchange words become three controller words
    for (i = 0; i < 2; i++) begin
      nxt();
      xw[i] = seed[23:0];
      xpulse(5'h00, xw[i], 1);
      chk(held, 48'h0);
    end
    @(posedge i_clock);
    phase <= 1'b1;
    for (i = 0; i < 3; i++) begin
      pm.hold_req(1'b0, 16'h0000, 10);
      @(negedge i_clock);
      got[i] = o_info_data;
      chk(o_info_data_oe, 48'h1);
    end
    // stage two shows the word fetched on the previous request
    chk(got[0], 48'h0);
    chk(got[1], cword({xw[0], xw[1]}, 0));
    chk(got[2], cword({xw[0], xw[1]}, 1));
    @(posedge i_clock);
    phase <= 1'b0;
    repeat (8) @(negedge i_clock);
    chk(o_info_data_oe, 48'h0);
    @(posedge i_clock);
    link <= 1'b1;
    repeat (30) @(negedge i_clock);
    chk(o_timeout, 48'h0);
    for (k = 0; k < 4 * TO && o_timeout !== 1'b1; k++) @(negedge i_clock);
    bound(k, 4 * TO);
    chk(o_timeout, 48'h1);
    pm.hold_req(1'b1, 16'h3C3C, 8);
    @(negedge i_clock);
    chk(o_timeout, 48'h0);
    results();
  end
endmodule
